/* File: verilog/cxe_pkg.sv */
// package for the conditional-execute and flag-effect unit
// assumes a 32-bit axi4-lite register bus and a single 40 mhz clock
package cxe_pkg;

  // register byte offsets
  localparam logic [7:0] CXE_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CXE_INSTR_OFS  = 8'h04;
  localparam logic [7:0] CXE_DEST_OFS   = 8'h08;
  localparam logic [7:0] CXE_SRC_OFS    = 8'h0c;
  localparam logic [7:0] CXE_STATUS_OFS = 8'h10;
  localparam logic [7:0] CXE_PC_OFS     = 8'h14;
  localparam logic [7:0] CXE_CORES_OFS  = 8'h18;
  localparam logic [7:0] CXE_HUBCFG_OFS = 8'h1c;

  // instruction field positions
  localparam int CXE_OPC_LSB  = 26;
  localparam int CXE_EFF_ZERO_WR  = 25;
  localparam int CXE_EFF_CARRY_WR = 24;
  localparam int CXE_EFF_WR   = 23;
  localparam int CXE_EFF_IMM  = 22;
  localparam int CXE_COND_LSB = 18;
  localparam int CXE_DST_LSB  = 9;
  localparam int CXE_SRC_LSB  = 0;

  // status register bit positions
  localparam int CXE_ST_BUSY   = 0;
  localparam int CXE_ST_CARRY  = 1;
  localparam int CXE_ST_ZERO   = 2;
  localparam int CXE_ST_EXEC   = 3;
  localparam int CXE_ST_BRANCH = 4;
  localparam int CXE_ST_WROTE  = 5;
  localparam int CXE_ST_DORM   = 6;

  // opcodes and hub operation codes
  localparam logic [5:0] CXE_OP_HUB  = 6'h03;
  localparam logic [5:0] CXE_OP_DEC_BRANCH = 6'h39;
  localparam logic [5:0] CXE_OP_AND  = 6'h18;
  localparam logic [5:0] CXE_OP_ANDN = 6'h19;
  localparam logic [2:0] CXE_HUB_STOP = 3'h3;

  // condition codes
  localparam logic [3:0] CXE_COND_ALWAYS = 4'hf;
  localparam logic [3:0] CXE_COND_NEVER  = 4'h0;

  // timing, in clock cycles
  localparam logic [4:0] CXE_T_BASIC    = 5'h04;
  localparam logic [4:0] CXE_T_FALLTHRU = 5'h08;
  localparam logic [4:0] CXE_T_HUB_MIN  = 5'h07;
  localparam logic [3:0] CXE_HUB_SLOTS  = 4'hf;

  // reset values
  localparam logic [31:0] CXE_ZERO_RST = 32'h0000_0000;
  localparam logic [7:0]  CXE_CORE_ID_RST = 8'h00;

  typedef enum logic [0:0] {
    CXE_IDLE,
    CXE_RUN
  } cxe_state_t;

endpackage

/* File: verilog/cxe_exec_unit.sv */
// conditional-execute unit: condition test, flag effects, decrement-branch, core stop
// assumes an axi4-lite master on the register bus and inputs synchronous to sys_clk_i
//
// What this block does
// RULE_01: stop-core hub op halts core named in dest
// RULE_02: dormant core loses its clock enable
// RULE_03: hub instructions stall seven to twenty-two clocks
// RULE_04: four-bit condition; 1111 always, 0000 never
// RULE_05: false condition is a four-cycle no-op
// RULE_06: 1010 needs zero set, 0101 zero clear
// RULE_07: 1100 needs carry set, 0011 carry clear
// RULE_08: and-codes test both flags together
// RULE_09: or-codes pass when either term holds
// RULE_10: condition bit selected by index carry,zero
// RULE_11: effect bits steer flag and result writes
// RULE_12: clear effect bit leaves its flag alone
// RULE_13: no-result computes, updates flags, skips destination
// RULE_14: and sets carry to result parity
// RULE_15: and-not uses inverted source, zero on zero
// RULE_16: decrement destination, branch when nonzero
// RULE_17: decrement sets zero on zero, carry on borrow
// RULE_18: decrement takes four branching, eight falling through
// RULE_19: decremented value written unless no-result
// RULE_20: branch target register or nine-bit immediate
`timescale 1ns/10ps
`default_nettype none
module cxe_exec_unit
  import cxe_pkg::*;
#(
  parameter int NUM_CORES = 8
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [7:0]           s_axi_awaddr_i,
  input  wire logic [2:0]           s_axi_awprot_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [7:0]           s_axi_araddr_i,
  input  wire logic [2:0]           s_axi_arprot_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  output logic [NUM_CORES-1:0]      core_clk_en_o,
  output logic                      busy_o
);

  // condition test: bit {carry,zero} of the field covers every code
  function automatic logic cond_pass(input logic [3:0] condition_field, input logic c, input logic z);
    cond_pass = condition_field[{c, z}]; // [RULE_04] [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_10]
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    merge_bytes = r;
  endfunction

  // bus slave state
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic        wr_fire;

  // software-visible registers
  logic [31:0] instr_reg;
  logic [31:0] dest_reg;
  logic [31:0] src_reg;
  logic [8:0]  pc_reg;
  logic        carry_reg;
  logic        zero_reg;
  logic        exec_reg;
  logic        branch_reg;
  logic        wrote_reg;
  logic [NUM_CORES-1:0] dormant_reg;
  logic [2:0]  core_id_reg;

  // execution state
  cxe_state_t  state_reg;
  logic [4:0]  cnt_reg;
  logic [3:0]  hub_slot_reg;
  logic [31:0] run_instr_reg;
  logic [31:0] run_dest_reg;
  logic [31:0] run_src_reg;

  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid_i && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= CXE_ZERO_RST;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_i && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  assign s_axi_awready_o = !aw_held_reg;
  assign s_axi_wready_o  = !w_held_reg;

  logic wr_mapped;
  always_comb begin
    case (aw_addr_reg[7:2])
      CXE_CTRL_OFS[7:2], CXE_INSTR_OFS[7:2], CXE_DEST_OFS[7:2], CXE_SRC_OFS[7:2],
      CXE_STATUS_OFS[7:2], CXE_PC_OFS[7:2], CXE_CORES_OFS[7:2], CXE_HUBCFG_OFS[7:2]: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'b00;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? 2'b00 : 2'b11;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o  = bresp_reg;

  // software writes, decoded once
  logic        sw_go;
  logic        wr_instr;
  logic        wr_dest;
  logic        wr_src;
  logic        wr_status;
  logic        wr_pc;
  logic        wr_cores;
  logic        wr_hubcfg;
  assign sw_go     = wr_fire && aw_addr_reg == CXE_CTRL_OFS && w_strb_reg[0] && w_data_reg[0];
  assign wr_instr  = wr_fire && aw_addr_reg == CXE_INSTR_OFS;
  assign wr_dest   = wr_fire && aw_addr_reg == CXE_DEST_OFS;
  assign wr_src    = wr_fire && aw_addr_reg == CXE_SRC_OFS;
  assign wr_status = wr_fire && aw_addr_reg == CXE_STATUS_OFS && w_strb_reg[0];
  assign wr_pc     = wr_fire && aw_addr_reg == CXE_PC_OFS;
  assign wr_cores  = wr_fire && aw_addr_reg == CXE_CORES_OFS && w_strb_reg[0];
  assign wr_hubcfg = wr_fire && aw_addr_reg == CXE_HUBCFG_OFS && w_strb_reg[0];

  // decode of the instruction being started
  logic [5:0]  opc;
  logic [3:0]  cond;
  logic [31:0] src_opnd;
  logic        passes;
  logic        is_hub;
  logic        own_dormant;
  logic        start;
  logic [3:0]  own_slot;
  logic [3:0]  hub_wait;

  assign opc      = instr_reg[CXE_OPC_LSB +: 6];
  assign cond     = instr_reg[CXE_COND_LSB +: 4];
  // immediate bit picks the nine-bit literal over the register value
  assign src_opnd = instr_reg[CXE_EFF_IMM] ? {23'h0, instr_reg[CXE_SRC_LSB +: 9]} : src_reg; // [RULE_20]
  assign passes   = cond_pass(cond, carry_reg, zero_reg);
  assign is_hub   = opc == CXE_OP_HUB;
  assign own_dormant = dormant_reg[core_id_reg];
  // a go while running or while this core sleeps is dropped: nothing can fetch it
  assign start    = sw_go && state_reg == CXE_IDLE && !own_dormant;
  // each core owns one of the sixteen hub clocks
  assign own_slot = {core_id_reg, 1'b0};
  assign hub_wait = own_slot - hub_slot_reg;

  // decrement-branch look-ahead, used for the cycle count only
  logic [31:0] dec_now;
  assign dec_now = dest_reg - 32'h1;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      hub_slot_reg <= 4'h0;
    end else begin
      hub_slot_reg <= hub_slot_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg     <= CXE_IDLE;
      cnt_reg       <= 5'h00;
      run_instr_reg <= CXE_ZERO_RST;
      run_dest_reg  <= CXE_ZERO_RST;
      run_src_reg   <= CXE_ZERO_RST;
      exec_reg      <= 1'b0;
    end else begin
      case (state_reg)
        CXE_IDLE: begin
          if (start) begin
            state_reg     <= CXE_RUN;
            run_instr_reg <= instr_reg;
            run_dest_reg  <= dest_reg;
            run_src_reg   <= src_opnd;
            exec_reg      <= passes;
            if (!passes) begin
              cnt_reg <= CXE_T_BASIC - 5'h1; // [RULE_05]
            end else if (is_hub) begin
              cnt_reg <= CXE_T_HUB_MIN - 5'h1 + {1'b0, hub_wait}; // [RULE_03]
            end else if (opc == CXE_OP_DEC_BRANCH && dec_now == CXE_ZERO_RST) begin
              cnt_reg <= CXE_T_FALLTHRU - 5'h1; // [RULE_18]
            end else begin
              cnt_reg <= CXE_T_BASIC - 5'h1; // [RULE_18]
            end
          end
        end
        CXE_RUN: begin
          if (cnt_reg == 5'h00) begin
            state_reg <= CXE_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 5'h1;
          end
        end
        default: state_reg <= CXE_IDLE;
      endcase
    end
  end

  // results of the running instruction, applied on its last cycle
  logic [5:0]  r_opc;
  logic        r_zero_en;
  logic        r_carry_en;
  logic        r_wr;
  logic        finish;
  logic        commit;
  logic [31:0] result;
  logic        res_c;
  logic        res_z;
  logic        known;
  logic        take_branch;

  assign r_opc  = run_instr_reg[CXE_OPC_LSB +: 6];
  assign r_zero_en  = run_instr_reg[CXE_EFF_ZERO_WR]; // [RULE_11]
  assign r_carry_en = run_instr_reg[CXE_EFF_CARRY_WR]; // [RULE_11]
  assign r_wr   = run_instr_reg[CXE_EFF_WR]; // [RULE_11]
  assign finish = state_reg == CXE_RUN && cnt_reg == 5'h00;
  assign commit = finish && exec_reg; // [RULE_05]

  always_comb begin
    result      = run_dest_reg;
    res_c       = carry_reg;
    res_z       = zero_reg;
    known       = 1'b0;
    take_branch = 1'b0;
    case (r_opc)
      CXE_OP_AND: begin
        result = run_dest_reg & run_src_reg;
        res_c  = ^result; // [RULE_14]
        res_z  = result == CXE_ZERO_RST;
        known  = 1'b1;
      end
      CXE_OP_ANDN: begin
        result = run_dest_reg & ~run_src_reg; // [RULE_15]
        res_c  = ^result;
        res_z  = result == CXE_ZERO_RST; // [RULE_15]
        known  = 1'b1;
      end
      CXE_OP_DEC_BRANCH: begin
        result      = run_dest_reg - 32'h1; // [RULE_16]
        res_z       = result == CXE_ZERO_RST; // [RULE_17]
        res_c       = run_dest_reg == CXE_ZERO_RST; // [RULE_17]
        take_branch = result != CXE_ZERO_RST; // [RULE_16]
        known       = 1'b1;
      end
      default: begin
        result = run_dest_reg;
      end
    endcase
  end

  // stop-core: hub op with the stop code in the source, target id from dest
  logic stop_now;
  assign stop_now = commit && r_opc == CXE_OP_HUB && run_src_reg[2:0] == CXE_HUB_STOP; // [RULE_01]

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else if (commit && known) begin
      // a clear effect bit leaves the flag as it was
      if (r_carry_en) begin
        carry_reg <= res_c; // [RULE_12] [RULE_13]
      end
      if (r_zero_en) begin
        zero_reg <= res_z; // [RULE_12] [RULE_13]
      end
    end else if (wr_status && state_reg == CXE_IDLE) begin
      carry_reg <= w_data_reg[CXE_ST_CARRY];
      zero_reg  <= w_data_reg[CXE_ST_ZERO];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dest_reg  <= CXE_ZERO_RST;
      wrote_reg <= 1'b0;
    end else if (commit) begin
      // stop-core writes nothing; other ops only with the result bit set
      wrote_reg <= known && r_wr;
      if (known && r_wr) begin
        dest_reg <= result; // [RULE_13] [RULE_19]
      end
    end else if (wr_dest) begin
      dest_reg <= merge_bytes(dest_reg, w_data_reg, w_strb_reg);
    end else if (finish) begin
      wrote_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pc_reg     <= 9'h000;
      branch_reg <= 1'b0;
    end else if (finish) begin
      branch_reg <= commit && take_branch;
      if (commit && take_branch) begin
        pc_reg <= run_src_reg[8:0]; // [RULE_16] [RULE_20]
      end else begin
        pc_reg <= pc_reg + 9'h001;
      end
    end else if (wr_pc && state_reg == CXE_IDLE) begin
      pc_reg <= w_data_reg[8:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      instr_reg <= CXE_ZERO_RST;
      src_reg   <= CXE_ZERO_RST;
    end else begin
      if (wr_instr) begin
        instr_reg <= merge_bytes(instr_reg, w_data_reg, w_strb_reg);
      end
      if (wr_src) begin
        src_reg <= merge_bytes(src_reg, w_data_reg, w_strb_reg);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      core_id_reg <= CXE_CORE_ID_RST[2:0];
    end else if (wr_hubcfg) begin
      core_id_reg <= w_data_reg[2:0];
    end
  end

  // writing ones wakes cores; a stop in the same cycle wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dormant_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_CORES; i++) begin
        if (stop_now && run_dest_reg[2:0] == 3'(i)) begin
          dormant_reg[i] <= 1'b1; // [RULE_01]
        end else if (wr_cores && w_data_reg[i]) begin
          dormant_reg[i] <= 1'b0;
        end
      end
    end
  end

  // enables feed the clock gates; a gated core stops toggling entirely
  assign core_clk_en_o = ~dormant_reg; // [RULE_02]
  assign busy_o        = state_reg == CXE_RUN;

  // read side
  logic [31:0] rd_data;
  logic        rd_ok;
  always_comb begin
    rd_data = CXE_ZERO_RST;
    rd_ok   = 1'b1;
    case (s_axi_araddr_i)
      CXE_CTRL_OFS:   rd_data = {31'h0, busy_o};
      CXE_INSTR_OFS:  rd_data = instr_reg;
      CXE_DEST_OFS:   rd_data = dest_reg;
      CXE_SRC_OFS:    rd_data = src_reg;
      CXE_STATUS_OFS: rd_data = {25'h0, own_dormant, wrote_reg, branch_reg, exec_reg, zero_reg, carry_reg,
                                 busy_o};
      CXE_PC_OFS:     rd_data = {23'h0, pc_reg};
      CXE_CORES_OFS:  rd_data = {{(32-NUM_CORES){1'b0}}, dormant_reg};
      CXE_HUBCFG_OFS: rd_data = {24'h0, hub_slot_reg, 1'b0, core_id_reg};
      default:        rd_ok   = 1'b0;
    endcase
  end

  assign s_axi_arready_o = !rvalid_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= CXE_ZERO_RST;
      rresp_reg  <= 2'b00;
    end else if (s_axi_arvalid_i && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_data;
      rresp_reg  <= rd_ok ? 2'b00 : 2'b11;
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o  = rdata_reg;
  assign s_axi_rresp_o  = rresp_reg;

endmodule
`default_nettype wire

/* File: verif/cxe_exec_checker.sv */
// assertions on the execute unit's cycle counts, core stops and read answers
// assumes binding onto cxe_exec_unit; one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module cxe_exec_checker #(
  parameter int NUM_CORES = 8
) (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 s_axi_arvalid_i,
  input wire logic                 s_axi_arready_o,
  input wire logic                 s_axi_rvalid_o,
  input wire logic                 s_axi_rready_i,
  input wire logic [31:0]          s_axi_rdata_o,
  input wire logic [1:0]           s_axi_rresp_o,
  input wire logic [NUM_CORES-1:0] core_clk_en_o,
  input wire logic                 busy_o
);
  logic [5:0] busy_cnt;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // saturates so a hung unit cannot wrap back into the legal range
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !busy_o) begin
      busy_cnt <= 6'h00;
    end else if (busy_cnt != 6'h3f) begin
      busy_cnt <= busy_cnt + 6'h01;
    end
  end
  busy_floor_a: assert property ($rose(busy_o) |-> busy_o [*4])
    else $error("instruction ended before four cycles");
  busy_ceiling_a: assert property (busy_o |-> busy_cnt < 6'h16)
    else $error("instruction ran past twenty-two cycles");
  busy_len_a: assert property ($fell(busy_o) |-> busy_cnt inside {6'h04, [6'h07:6'h16]})
    else $error("instruction length not allowed");
  stop_at_end_a: assert property (|($past(core_clk_en_o) & ~core_clk_en_o) |-> $fell(busy_o))
    else $error("core stopped outside instruction end");
  read_done_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer not retired");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  read_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while answer pending");
  decerr_data_a: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'b11 |-> s_axi_rdata_o == 32'h0)
    else $error("unmapped read returned data");
  cover property ($fell(busy_o) && busy_cnt == 6'h08);
  cover property ($fell(busy_o) && busy_cnt > 6'h08);
  cover property ($fell(core_clk_en_o[0]));
endmodule
bind cxe_exec_unit cxe_exec_checker #(.NUM_CORES(NUM_CORES)) i_cxe_exec_checker (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .core_clk_en_o(core_clk_en_o),
  .busy_o(busy_o));
`default_nettype wire

/* File: verif/cxe_core_model.sv */
// far-side cores: each counts the clock pulses that reach it through its enable
// assumes enables change just after rising edges of the system clock
`timescale 1ns/10ps
`default_nettype none
module cxe_core_model (
  input  wire logic             sys_clk_i,
  input  wire logic [7:0]       core_clk_en_i,
  output wire logic [7:0][15:0] ticks_o
);
  for (genvar i = 0; i < 8; i++) begin : g_core
    logic        en = 1'b1;
    logic [15:0] cnt = 16'h0000;
    wire logic   gclk;
    // latched in the low phase so the gated clock cannot glitch
    always @(sys_clk_i or core_clk_en_i[i]) if (!sys_clk_i) en <= core_clk_en_i[i];
    assign gclk = sys_clk_i & en;
    always @(posedge gclk) cnt <= cnt + 16'h0001;
    assign ticks_o[i] = cnt;
  end
endmodule
`default_nettype wire

/* File: verif/tb_cxe_exec_unit.sv */
// self-checking bench for the conditional-execute unit
// assumes the handed-over register map and timing; far-side cores modelled apart
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_total++; $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_cxe_exec_unit
  import cxe_pkg::*;
;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             awv = 1'b0;
  logic             wv = 1'b0;
  logic             bready = 1'b0;
  logic             arv = 1'b0;
  logic             rready = 1'b0;
  logic [7:0]       awaddr = 8'h00;
  logic [7:0]       araddr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic [5:0]       run_len = 6'h00;
  logic [5:0]       last_len = 6'h00;
  logic [1:0]       wr_resp = 2'b00;
  logic             awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0]       bresp, rresp;
  logic [31:0]      rdata;
  logic [7:0]       clk_en;
  logic [7:0][15:0] ticks;
  int               err_total = 0;
  int               checked = 0;

  always #12.5 clk = ~clk;

  cxe_exec_unit #(.NUM_CORES(8)) i_cxe_exec_unit (
    .sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .core_clk_en_o(clk_en), .busy_o(busy));

  cxe_core_model i_cxe_core_model (.sys_clk_i(clk), .core_clk_en_i(clk_en), .ticks_o(ticks));

  // length of the last busy run, measured independently of the bus
  always @(posedge clk) begin
    if (busy) begin
      run_len <= run_len + 6'h01;
    end else if (run_len != 6'h00) begin
      last_len <= run_len;
      run_len <= 6'h00;
    end
  end

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic stall;
    err_total++;
    $display("ERROR wait expected done seen timeout");
    complete_run();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid) break;
    end
    wr_resp = bresp;
    bready <= 1'b0;
    if (n == 60) stall();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 60) stall();
  endtask

  function automatic logic [31:0] mk(input logic [5:0] op, input logic [3:0] eff, input logic [3:0] cnd,
                                     input logic [8:0] src);
    return {op, eff, cnd, 9'h000, src};
  endfunction

  task automatic exec(input logic [31:0] ins, output logic [5:0] len);
    int n;
    axw(CXE_INSTR_OFS, ins);
    axw(CXE_CTRL_OFS, 32'h1);
    for (n = 0; n < 60 && busy; n++) @(posedge clk);
    @(posedge clk);
    len = last_len;
    if (n == 60) stall();
  endtask

  // loads operands, flags {zero,carry} and pc 0x010, runs one instruction, checks cycles, dest, flags and pc
  task automatic run_case(input logic [31:0] d, input logic [31:0] s, input logic [1:0] zc,
                          input logic [31:0] ins, input logic [5:0] n, input logic [31:0] ed,
                          input logic [1:0] ezc, input logic [8:0] epc);
    logic [31:0] v;
    logic [1:0]  r;
    logic [5:0]  len;
    axw(CXE_DEST_OFS, d);
    axw(CXE_SRC_OFS, s);
    axw(CXE_PC_OFS, 32'h10);
    axw(CXE_STATUS_OFS, {29'h0, zc, 1'b0});
    exec(ins, len);
    `CHK("cycles", n, len)
    axr(CXE_DEST_OFS, v, r);
    `CHK("dest", ed, v)
    axr(CXE_STATUS_OFS, v, r);
    `CHK("flags", ezc, v[2:1])
    axr(CXE_PC_OFS, v, r);
    `CHK("pc", epc, v[8:0])
  endtask

  task automatic reset_map;
    logic [31:0] v;
    logic [1:0]  r;
    `CHK("enables after reset", 8'hff, clk_en)
    `CHK("busy after reset", 1'b0, busy)
    axr(CXE_STATUS_OFS, v, r);
    `CHK("status reset", 32'h0, v)
    axr(8'h20, v, r);
    `CHK("unmapped read resp", 2'b11, r)
    `CHK("unmapped read data", 32'h0, v)
    axw(8'h20, 32'hffff_ffff);
    `CHK("unmapped write resp", 2'b11, wr_resp)
  endtask

  // every code against every flag pair; a pass writes 0x0f with both flags cleared
  task automatic cond_table;
    logic [1:0] zc;
    for (int cd = 0; cd < 16; cd++) begin
      for (int f = 0; f < 4; f++) begin
        zc = {f[0], f[1]};
        run_case(32'hff, 32'hf, zc, mk(CXE_OP_AND, 4'he, cd[3:0], 9'h0), 6'h4, cd[f] ? 32'hf : 32'hff,
                 cd[f] ? 2'b00 : zc, 9'h11);
      end
    end
  endtask

  task automatic effect_cases;
    run_case(32'hf7, 32'h7, 2'b10, mk(CXE_OP_AND, 4'h4, 4'hf, 9'h0), 6'h4, 32'hf7, 2'b11, 9'h11);
    run_case(32'hf7, 32'h7, 2'b00, mk(CXE_OP_AND, 4'h2, 4'hf, 9'h0), 6'h4, 32'h7, 2'b00, 9'h11);
    run_case(32'hf0, 32'hff, 2'b01, mk(CXE_OP_ANDN, 4'ha, 4'hf, 9'h0), 6'h4, 32'h0, 2'b11, 9'h11);
    run_case(32'hf0, 32'h0, 2'b10, mk(CXE_OP_ANDN, 4'h9, 4'hf, 9'h38), 6'h4, 32'hf0, 2'b00, 9'h11);
  endtask

  task automatic dec_branch_cases;
    run_case(32'h2, 32'h0, 2'b00, mk(CXE_OP_DEC_BRANCH, 4'hf, 4'hf, 9'h55), 6'h4, 32'h1, 2'b00, 9'h55);
    run_case(32'h1, 32'h0, 2'b00, mk(CXE_OP_DEC_BRANCH, 4'hf, 4'hf, 9'h55), 6'h8, 32'h0, 2'b10, 9'h11);
    run_case(32'h0, 32'h0, 2'b00, mk(CXE_OP_DEC_BRANCH, 4'hd, 4'hf, 9'h55), 6'h4, 32'h0, 2'b01, 9'h55);
    run_case(32'h3, 32'h1a3, 2'b11, mk(CXE_OP_DEC_BRANCH, 4'h2, 4'hf, 9'h0), 6'h4, 32'h2, 2'b11, 9'h1a3);
  endtask

  // own core is id 0, stopped last and then woken so later starts are not blocked
  task automatic hub_stop;
    logic [31:0] v;
    logic [1:0]  r;
    logic [5:0]  len;
    logic [15:0] t;
    for (int id = 7; id >= 0; id--) begin
      axw(CXE_DEST_OFS, 32'h8 + id);
      exec(mk(CXE_OP_HUB, 4'h1, CXE_COND_ALWAYS, {6'h00, CXE_HUB_STOP}), len);
      `CHK("hub cycles", 1'b1, len inside {[6'h07:6'h16]})
      `CHK("core enables", ~(8'h01 << id), clk_en)
      t = ticks[id];
      repeat (16) @(posedge clk);
      `CHK("dormant ticks", t, ticks[id])
      axr(CXE_DEST_OFS, v, r);
      `CHK("hub dest", 32'h8 + id, v)
      axw(CXE_CORES_OFS, 32'h1 << id);
      `CHK("woken enables", 8'hff, clk_en)
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reset_map();
    cond_table();
    effect_cases();
    dec_branch_cases();
    hub_stop();
    complete_run();
  end
endmodule
`default_nettype wire
